// ---- design/wireless_rx_protection_control.sv ----
/*
 * control of a wireless power receiver: start-up and shutdown, strap
 * configuration, regulator enable, protections, uplink packets, registers.
 * assumes analog comparator levels on pins, an ADC on the same clock with a
 * req/done handshake, an AXI4-Lite master, and an external 10 MHz clock.
 */
// Local design decisions: the register addresses and the AXI4-Lite register port.
// Functional notes
// [R1] bias rail good starts control and reporting
// [R2] bias rail lost forces shutdown
// [R3] regulator on at target plus headrooms
// [R4] uplink by switching both modulation switches
// [R5] overcurrent drives clamp and interrupts host
// [R6] overcurrent limits current and sends end packet
// [R7] level one clamps, end packet or faster CE
// [R8] level two sends end packet, hard cutoff
// [R9] clamp pin held low 200ms per overvoltage
// [R10] output below 1V switches regulator off
// [R11] thermistor against four hot thresholds, end packet
// [R12] enabled cold protection below zero, end packet
// [R13] temperature end packet needs its enable
// [R14] die at 150C sends end packet
// [R15] tracking makes target follow battery pin
// [R16] host port address 0x60, one-byte index
// [R17] regulator enable pin active low
// [R18] 10bit ADC gives received power report
// [R19] ADC samples thermistor/battery pin for both uses
// [R20] strap current on, offset pin window check
// [R21] strap results to params, current stops
// [R22] coil pin sets coil param, offset pin offset
// [R23] reading event flags clears them
// [R24] each event sets flag, interrupt until read
// [R25] end packet goes first at next slot
`timescale 1ns/10ps
`include "rx_protect_map.svh"
module wireless_rx_protection_control
	import rx_protect_pkg::*;
#(
	parameter int CLAMP_CYCLES = `CLAMP_HOLD_MS * `CLK_KHZ,
	parameter int BIT_CYCLES = `BIT_PERIOD_US * `CLK_KHZ / 1000,
	parameter int CE_CYCLES = `CE_PERIOD_MS * `CLK_KHZ,
	parameter int CE_FAST_CYCLES = `CE_FAST_MS * `CLK_KHZ
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// analog levels and enable pin, asynchronous
	input protIn_t protRaw,
	// converter handshake
	output logic adcReq,
	output adcCh_t adcChannel,
	input wire logic adcDone,
	input wire logic [9:0] adcResult,
	// analog controls
	output logic rectEnable,
	output logic ldoEnable,
	output logic currentLimit,
	output logic hardCutoff,
	output logic strapCurrentEn,
	output logic [9:0] voutTarget,
	// open-drain pins
	output logic clampOut,
	output logic clampOe_n,
	output logic [1:0] loadModOut,
	output logic [1:0] loadModOe_n,
	// host interrupt
	output logic hostIrq,
	// AXI4-Lite slave
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	// headroom lookups
	function automatic logic [10:0] lightCode(input logic [1:0] s);
		return (s == 2'h0) ? `LIGHT_CODE_0 : (s == 2'h1) ? `LIGHT_CODE_1 :
			(s == 2'h2) ? `LIGHT_CODE_2 : `LIGHT_CODE_3;
	endfunction
	function automatic logic [10:0] dropCode(input logic [1:0] s);
		return (s == 2'h0) ? `DROP_CODE_0 : (s == 2'h1) ? `DROP_CODE_1 :
			(s == 2'h2) ? `DROP_CODE_2 : `DROP_CODE_3;
	endfunction
	// byte address check, bits 31 to 10 must be zero
	function automatic logic addrOk(input logic [31:0] a);
		return a[31:10] == 22'h0;
	endfunction

	protIn_t protMeta_q, protLvl_q, prevLvl_q; // two-stage sync, then edge history
	ctlState_t state_q; // control sequence
	logic adcReq_q; // converter request held to done
	adcCh_t adcCh_q; // channel being converted
	logic [1:0] rrCh_q; // run-time channel rotation
	logic [9:0] vrectCode_q, ioutCode_q, thermCode_q, ofsStrap_q; // last samples
	logic thermValid_q; // thermistor sampled since run
	logic [19:0] power_q; // received power product
	logic strapMode_q, strapCur_q; // strap configuration mode, current source
	logic [4:0] ctrl_q; // force bits
	logic [7:0] ept_q; // end message and host enable
	logic [7:0] flags_q; // sticky event flags
	logic [5:0] coilRes_q; // coil resistance parameter
	logic [4:0] option_q; // option bits
	logic [3:0] offset_q; // power offset parameter
	logic [7:0] vout_q; // programmed output
	logic [1:0] hotSel_q, dropSel_q, lightSel_q; // threshold selects
	logic ldoOn_q, ldoEn_q, hotPrev_q, coldPrev_q; // regulator latch, output, temp history
	logic [21:0] clampCnt_q; // clamp hold counter
	logic clampOn_q; // clamp pin drive
	logic eptPend_q; // end packet queued
	logic [12:0] bitDiv_q; // uplink bit divider
	logic [21:0] pktTimer_q; // packet slot timer
	logic [15:0] txShift_q; // packet bits, msb first
	logic [4:0] txBits_q; // bits left in packet
	logic ceNext_q; // alternate control error and power
	logic modOn_q; // modulation switches closed

	// shared decoded conditions
	wire run = state_q == ST_RUN;
	wire tracking = option_q[`OPT_TRACK_EN] & ~ctrl_q[`CTRL_FORCE_TRACK_OFF];
	wire [10:0] startLevel = {1'b0, voutTarget} + lightCode(lightSel_q) + dropCode(dropSel_q);
	wire vrectHigh = {1'b0, vrectCode_q} >= startLevel;
	wire [9:0] hotCode = (hotSel_q == 2'h0) ? `HOT_CODE_0 : (hotSel_q == 2'h1) ? `HOT_CODE_1 :
		(hotSel_q == 2'h2) ? `HOT_CODE_2 : `HOT_CODE_3;
	wire hotLvl = run & thermValid_q & ~tracking & (thermCode_q <= hotCode); // see [R11]
	wire coldLvl = run & thermValid_q & ~tracking & option_q[`OPT_COLD_EN]
		& (thermCode_q >= `COLD_CODE); // see [R12]
	wire strapInWindow = (adcResult >= `STRAP_LO_CODE) & (adcResult <= `STRAP_HI_CODE);
	// protection events, rising edges of synchronised levels, start event on bias good while off
	wire evStart = (state_q == ST_OFF) & protLvl_q.biasOk;
	wire evOv1 = run & protLvl_q.ovOne & ~prevLvl_q.ovOne;
	wire evOv2 = run & protLvl_q.ovTwo & ~prevLvl_q.ovTwo;
	wire evOcp = run & protLvl_q.overCur & ~prevLvl_q.overCur;
	wire evShort = run & protLvl_q.outShort & ~prevLvl_q.outShort;
	wire evOtp = run & protLvl_q.dieHot & ~prevLvl_q.dieHot;
	wire evTemp = (hotLvl & ~hotPrev_q) | (coldLvl & ~coldPrev_q);
	// end packet requests per source
	wire eptOther = evOcp | evOv2 | evOtp | (evOv1 & option_q[`OPT_OV1_EPT_EN]); // see [R6] [R7] [R8] [R14]
	wire eptTemp = evTemp & option_q[`OPT_TEMP_EPT_EN]; // see [R13]
	wire ceFast = protLvl_q.ovOne & ~option_q[`OPT_OV1_EPT_EN]; // see [R7]
	// uplink slot start, end packet may go at once when idle
	wire txIdle = txBits_q == 5'h0;
	wire txStart = run & txIdle & (eptPend_q | (pktTimer_q == 22'h0)); // see [R25]
	wire [7:0] eptPayload = ept_q[`EPT_HOST_EN] ? {1'b0, ept_q[6:0]} : `EPT_REASON;
	wire [10:0] ceDiff = startLevel - {1'b0, vrectCode_q};
	// AXI bus
	logic awHave_q, wHave_q, awOk_q, wLane0_q, bvalid_q, rvalid_q;
	logic [7:0] awIdx_q;
	logic [7:0] wData_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] rdMux;
	logic rdHit;
	wire [7:0] arIdx = araddr[9:2]; // see [R16]
	wire arTake = arvalid & arready;
	wire doWrite = awHave_q & wHave_q & ~bvalid_q;
	wire wrHit = awOk_q & ((awIdx_q == `IDX_CTRL) | (awIdx_q == `IDX_EPT) |
		(awIdx_q == `IDX_COILRES) | (awIdx_q == `IDX_OPTION) | (awIdx_q == `IDX_OFFSET) |
		(awIdx_q == `IDX_VOUT) | (awIdx_q == `IDX_HOTSEL) | (awIdx_q == `IDX_DROPOUT) |
		(awIdx_q == `IDX_LIGHT));
	wire wrGo = doWrite & wrHit & wLane0_q;
	wire rdFlags = arTake & addrOk(araddr) & (arIdx == `IDX_FLAGS); // see [R23]
	logic [7:0] flagSet;

	// pin and analog level synchronisers, edge history
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			protMeta_q <= '0;
			protLvl_q <= '0;
			prevLvl_q <= '0;
		end
		else
		begin
			protMeta_q <= protRaw;
			protLvl_q <= protMeta_q;
			prevLvl_q <= protLvl_q;
		end
	end

	// start-up, strap configuration and shutdown sequence
	always_ff @(posedge clk)
	begin
		if (srst || !protLvl_q.biasOk) // see [R2]
		begin
			state_q <= ST_OFF;
			strapCur_q <= 1'b0;
		end
		else
			case (state_q)
				ST_OFF:
				begin
					state_q <= ST_STRAP_OFS; // see [R1]
					strapCur_q <= 1'b1; // see [R20]
				end
				ST_STRAP_OFS:
					if (adcDone && adcReq_q)
					begin
						// offset pin first, window selects strap mode
						state_q <= strapInWindow ? ST_STRAP_COIL : ST_RUN; // see [R20]
						strapCur_q <= strapInWindow;
					end
				ST_STRAP_COIL:
					if (adcDone && adcReq_q)
					begin
						state_q <= ST_RUN;
						strapCur_q <= 1'b0; // see [R21]
					end
				default:
					state_q <= ST_RUN;
			endcase
	end

	// converter requests, held until done
	always_ff @(posedge clk)
	begin
		if (srst || !protLvl_q.biasOk)
		begin
			adcReq_q <= 1'b0;
			adcCh_q <= CH_RECTIFIED_RAIL;
			rrCh_q <= 2'h0;
		end
		else if (adcReq_q)
		begin
			if (adcDone)
			begin
				adcReq_q <= 1'b0;
				if (run)
					rrCh_q <= (rrCh_q == 2'h2) ? 2'h0 : rrCh_q + 2'h1;
			end
		end
		else if (state_q != ST_OFF)
		begin
			adcReq_q <= 1'b1;
			// strap pins during configuration, then rail, current, thermistor
			if (state_q == ST_STRAP_OFS)
				adcCh_q <= CH_OFFSET_STRAP;
			else if (state_q == ST_STRAP_COIL)
				adcCh_q <= CH_COIL_STRAP;
			else
				adcCh_q <= adcCh_t'({1'b0, rrCh_q}); // see [R18] [R19]
		end
	end

	// converter results and received power
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			vrectCode_q <= 10'h000;
			ioutCode_q <= 10'h000;
			thermCode_q <= 10'h000;
			ofsStrap_q <= 10'h000;
			thermValid_q <= 1'b0;
			power_q <= 20'h00000;
			strapMode_q <= 1'b0;
		end
		else
		begin
			if (adcReq_q && adcDone)
				case (adcCh_q)
					CH_RECTIFIED_RAIL: vrectCode_q <= adcResult;
					CH_IOUT: ioutCode_q <= adcResult;
					CH_THERM: thermCode_q <= adcResult; // see [R19]
					CH_OFFSET_STRAP: ofsStrap_q <= adcResult;
					default: ofsStrap_q <= ofsStrap_q;
				endcase
			if (adcReq_q && adcDone && adcCh_q == CH_THERM)
				thermValid_q <= 1'b1;
			else if (!run)
				thermValid_q <= 1'b0;
			power_q <= vrectCode_q * ioutCode_q; // see [R18]
			if (state_q == ST_STRAP_OFS && adcReq_q && adcDone)
				strapMode_q <= strapInWindow; // see [R20]
		end
	end

	// software registers, strap results load the parameters
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_q <= 5'h00;
			ept_q <= 8'h00;
			coilRes_q <= `RST_COILRES;
			option_q <= `RST_OPTION;
			offset_q <= `RST_OFFSET;
			vout_q <= `RST_VOUT;
			hotSel_q <= 2'h0;
			dropSel_q <= 2'h0;
			lightSel_q <= 2'h0;
		end
		else if (state_q == ST_STRAP_COIL && adcReq_q && adcDone)
		begin
			// coil pin to coil param, offset pin to offset, scaled by 5/8 and 5/16
			coilRes_q <= 6'(({3'h0, adcResult} * 13'h0005) >> 3); // see [R21] [R22]
			offset_q <= 4'(({3'h0, ofsStrap_q} * 13'h0005) >> 4); // see [R22]
		end
		else if (wrGo)
		begin
			if (awIdx_q == `IDX_CTRL)
				ctrl_q <= wData_q[4:0];
			else if (awIdx_q == `IDX_EPT)
				ept_q <= wData_q;
			else if (awIdx_q == `IDX_COILRES)
				coilRes_q <= wData_q[5:0];
			else if (awIdx_q == `IDX_OPTION)
				option_q <= wData_q[4:0];
			else if (awIdx_q == `IDX_OFFSET)
				offset_q <= wData_q[3:0];
			else if (awIdx_q == `IDX_VOUT)
				vout_q <= wData_q;
			else if (awIdx_q == `IDX_HOTSEL)
				hotSel_q <= wData_q[1:0];
			else if (awIdx_q == `IDX_DROPOUT)
				dropSel_q <= wData_q[1:0];
			else
				lightSel_q <= wData_q[1:0];
		end
	end

	// event flags: set wins over the read clear
	assign flagSet[0] = 1'b0;
	assign flagSet[`FLAG_STARTUP] = evStart;
	assign flagSet[`FLAG_SHORT] = evShort;
	assign flagSet[`FLAG_OCP] = evOcp; // see [R5]
	assign flagSet[`FLAG_OV2] = evOv2;
	assign flagSet[`FLAG_OV1] = evOv1;
	assign flagSet[`FLAG_OTP] = evOtp;
	assign flagSet[`FLAG_TEMP] = evTemp;
	always_ff @(posedge clk)
	begin
		if (srst)
			flags_q <= 8'h00;
		else
			flags_q <= (rdFlags ? 8'h00 : flags_q) | flagSet; // see [R23] [R24]
	end
	assign hostIrq = flags_q != 8'h00; // see [R24]

	// regulator, clamp and cutoff
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ldoOn_q <= 1'b0;
			ldoEn_q <= 1'b0;
			clampCnt_q <= 22'h0;
			clampOn_q <= 1'b0;
			hotPrev_q <= 1'b0;
			coldPrev_q <= 1'b0;
		end
		else
		begin
			hotPrev_q <= hotLvl;
			coldPrev_q <= coldLvl;
			if (!run || protLvl_q.outShort || protLvl_q.ovTwo)
				ldoOn_q <= 1'b0; // see [R10] [R8]
			else if (vrectHigh)
				ldoOn_q <= 1'b1; // see [R3]
			// enable pin high blocks the regulator, forces as programmed
			ldoEn_q <= run & ~protLvl_q.regEnable_n & ~protLvl_q.outShort
				& ~ctrl_q[`CTRL_FORCE_LDO_OFF]
				& (ldoOn_q | ctrl_q[`CTRL_FORCE_LDO_ON]); // see [R17]
			if (evOv1 || evOv2)
				clampCnt_q <= 22'(CLAMP_CYCLES); // see [R9]
			else if (clampCnt_q != 22'h0)
				clampCnt_q <= clampCnt_q - 22'h1;
			clampOn_q <= (clampCnt_q != 22'h0) | (run & protLvl_q.overCur); // see [R5] [R7]
		end
	end
	assign ldoEnable = ldoEn_q;
	assign clampOut = 1'b0;
	assign clampOe_n = ~clampOn_q;
	assign currentLimit = run & protLvl_q.overCur; // see [R6]
	assign hardCutoff = run & protLvl_q.ovTwo; // see [R8]
	assign rectEnable = state_q != ST_OFF; // see [R1]
	assign strapCurrentEn = strapCur_q;
	assign voutTarget = tracking ? thermCode_q : {vout_q, 2'b00}; // see [R15]
	assign adcReq = adcReq_q;
	assign adcChannel = adcCh_q;

	// end packet queue: a new request wins over the start that takes it
	always_ff @(posedge clk)
	begin
		if (srst || !run)
			eptPend_q <= 1'b0;
		else
			eptPend_q <= (eptPend_q & ~txStart) | eptOther | eptTemp; // see [R25]
	end

	// uplink packet sender, two bytes shifted out msb first
	always_ff @(posedge clk)
	begin
		if (srst || !run)
		begin
			bitDiv_q <= 13'h0;
			pktTimer_q <= 22'h0;
			txShift_q <= 16'h0;
			txBits_q <= 5'h0;
			ceNext_q <= 1'b1;
			modOn_q <= 1'b0;
		end
		else
		begin
			if (txStart)
			begin
				pktTimer_q <= ceFast ? 22'(CE_FAST_CYCLES - 1) : 22'(CE_CYCLES - 1); // see [R7]
				bitDiv_q <= 13'(BIT_CYCLES - 1);
				txBits_q <= 5'h10;
				if (eptPend_q)
					txShift_q <= {`HDR_EPT, eptPayload}; // see [R25]
				else if (ceNext_q || ceFast)
					txShift_q <= {`HDR_CE, ceDiff[10] ? 8'h00 : ceDiff[7:0]};
				else
					txShift_q <= {`HDR_POWER, power_q[19:12]}; // see [R18]
				if (!eptPend_q)
					ceNext_q <= ~ceNext_q;
			end
			else
			begin
				if (pktTimer_q != 22'h0)
					pktTimer_q <= pktTimer_q - 22'h1;
				if (!txIdle && bitDiv_q == 13'h0)
				begin
					bitDiv_q <= 13'(BIT_CYCLES - 1);
					txShift_q <= {txShift_q[14:0], 1'b0};
					txBits_q <= txBits_q - 5'h1;
				end
				else if (!txIdle)
					bitDiv_q <= bitDiv_q - 13'h1;
			end
			modOn_q <= ~txIdle & txShift_q[15]; // see [R4]
		end
	end
	assign loadModOut = 2'b00;
	assign loadModOe_n = {2{~modOn_q}}; // see [R4]

	// read decode
	always_comb
	begin
		rdHit = addrOk(araddr);
		rdMux = 32'h0;
		if (arIdx == `IDX_CTRL)
			rdMux[4:0] = ctrl_q;
		else if (arIdx == `IDX_EPT)
			rdMux[7:0] = ept_q;
		else if (arIdx == `IDX_FLAGS)
			rdMux[7:0] = flags_q;
		else if (arIdx == `IDX_STATUS)
			rdMux[4:0] = {strapMode_q, clampOn_q, ldoEn_q, state_q};
		else if (arIdx == `IDX_COILRES)
			rdMux[5:0] = coilRes_q;
		else if (arIdx == `IDX_OPTION)
			rdMux[4:0] = option_q;
		else if (arIdx == `IDX_OFFSET)
			rdMux[3:0] = offset_q;
		else if (arIdx == `IDX_VOUT)
			rdMux[7:0] = vout_q;
		else if (arIdx == `IDX_HOTSEL)
			rdMux[1:0] = hotSel_q;
		else if (arIdx == `IDX_DROPOUT)
			rdMux[1:0] = dropSel_q;
		else if (arIdx == `IDX_LIGHT)
			rdMux[1:0] = lightSel_q;
		else if (arIdx == `IDX_IOUT_LO)
			rdMux[1:0] = ioutCode_q[1:0];
		else if (arIdx == `IDX_IOUT_HI)
			rdMux[7:0] = ioutCode_q[9:2];
		else if (arIdx == `IDX_VBAT_LO)
			rdMux[1:0] = thermCode_q[1:0];
		else if (arIdx == `IDX_VBAT_HI)
			rdMux[7:0] = thermCode_q[9:2];
		else if (arIdx == `IDX_RECTIFIED_RAIL_LO)
			rdMux[1:0] = vrectCode_q[1:0];
		else if (arIdx == `IDX_RECTIFIED_RAIL_HI)
			rdMux[7:0] = vrectCode_q[9:2];
		else if (arIdx == `IDX_POWER)
			rdMux[19:0] = power_q;
		else
			rdHit = 1'b0;
	end

	// AXI write: address and data taken in either order, response after both
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awOk_q <= 1'b0;
			awIdx_q <= 8'h00;
			wData_q <= 8'h00;
			wLane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHave_q <= 1'b1;
				awIdx_q <= awaddr[9:2];
				awOk_q <= addrOk(awaddr);
			end
			if (wvalid && wready)
			begin
				wHave_q <= 1'b1;
				wData_q <= wdata[7:0];
				wLane0_q <= wstrb[0];
			end
			if (doWrite)
			begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wrHit ? 2'b00 : 2'b10;
			end
			else if (bvalid_q && bready)
				bvalid_q <= 1'b0;
		end
	end
	assign awready = ~awHave_q & ~bvalid_q;
	assign wready = ~wHave_q & ~bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// AXI read: one cycle answer, unmapped gives SLVERR
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= 2'b00;
		end
		else if (arTake)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rdHit ? rdMux : 32'h0;
			rresp_q <= rdHit ? 2'b00 : 2'b10;
		end
		else if (rvalid_q && rready)
			rvalid_q <= 1'b0;
	end
	assign arready = ~rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_SHUTDOWN: assert property (!protLvl_q.biasOk |=> state_q == ST_OFF ##1 !ldoEnable) // see [R2]
		else $error("control still active after bias rail loss");
	AST_LDO_THRESHOLD: assert property ($rose(ldoOn_q) |-> $past(vrectHigh) && $past(run)) // see [R3]
		else $error("regulator latched below start level");
	AST_OCP_CLAMP_IRQ: assert property (evOcp |=> hostIrq && flags_q[`FLAG_OCP] && clampOn_q) // see [R5]
		else $error("overcurrent without clamp or interrupt");
	AST_OCP_EPT: assert property (evOcp |=> eptPend_q) // see [R6]
		else $error("overcurrent did not queue end packet");
	AST_OV2_LDO_OFF: assert property (run && protLvl_q.ovTwo |=> !ldoOn_q ##1 !ldoEnable) // see [R8]
		else $error("regulator on during level two overvoltage");
	AST_CLAMP_HOLD: assert property (evOv1 |-> ##2 !clampOe_n [*8]) // see [R9]
		else $error("clamp pin not held after overvoltage");
	AST_SHORT_OFF: assert property (run && protLvl_q.outShort |-> ##2 !ldoEnable) // see [R10]
		else $error("regulator on during output short");
	AST_TEMP_NO_EPT: assert property (run && evTemp && !option_q[`OPT_TEMP_EPT_EN] && !eptOther
		&& !eptPend_q |=> !eptPend_q) // see [R13]
		else $error("temperature event sent end packet while disabled");
	AST_FLAG_READ: assert property (rdFlags && flagSet == 8'h00 |=> flags_q == 8'h00) // see [R23]
		else $error("event flags not cleared by read");
	AST_STRAP_STOP: assert property (run && $past(run) |-> !strapCurrentEn) // see [R21]
		else $error("strap current still on in run");
endmodule // wireless_rx_protection_control

// ---- design/rx_protect_map.svh ----
/*
 * register indices, field positions, reset values and timing figures of the
 * receiver control block.
 * assumes a 10 MHz clock and ADC codes of 9.766 mV per step.
 */
`ifndef RX_PROTECT_MAP_SVH
`define RX_PROTECT_MAP_SVH
// register indices, byte address is four times the index
`define IDX_CTRL 8'h04
`define IDX_EPT 8'h05
`define IDX_FLAGS 8'h06
`define IDX_STATUS 8'h07
`define IDX_COILRES 8'h14
`define IDX_OPTION 8'h15
`define IDX_OFFSET 8'h18
`define IDX_VOUT 8'h1D
`define IDX_HOTSEL 8'h1F
`define IDX_DROPOUT 8'h21
`define IDX_LIGHT 8'h22
`define IDX_IOUT_LO 8'h30
`define IDX_IOUT_HI 8'h31
`define IDX_VBAT_LO 8'h32
`define IDX_VBAT_HI 8'h33
`define IDX_RECTIFIED_RAIL_LO 8'h34
`define IDX_RECTIFIED_RAIL_HI 8'h35
`define IDX_POWER 8'h40
// reset values
`define RST_OPTION 5'h12
`define RST_COILRES 6'h16
`define RST_OFFSET 4'h2
`define RST_VOUT 8'h7F
// control and option bit positions
`define CTRL_FORCE_LDO_ON 0
`define CTRL_FORCE_LDO_OFF 2
`define CTRL_FORCE_TRACK_OFF 4
`define OPT_TRACK_EN 0
`define OPT_TEMP_EPT_EN 1
`define OPT_COLD_EN 2
`define OPT_OV1_EPT_EN 3
`define EPT_HOST_EN 7
// event flag positions
`define FLAG_STARTUP 1
`define FLAG_SHORT 2
`define FLAG_OCP 3
`define FLAG_OV2 4
`define FLAG_OV1 5
`define FLAG_OTP 6
`define FLAG_TEMP 7
// headroom codes, 9.766 mV steps
`define LIGHT_CODE_0 11'h0CD
`define LIGHT_CODE_1 11'h100
`define LIGHT_CODE_2 11'h066
`define LIGHT_CODE_3 11'h033
`define DROP_CODE_0 11'h014
`define DROP_CODE_1 11'h01D
`define DROP_CODE_2 11'h025
`define DROP_CODE_3 11'h00F
// thermistor resistance codes, 0.488 kOhm steps
`define HOT_CODE_0 10'h02E
`define HOT_CODE_1 10'h038
`define HOT_CODE_2 10'h044
`define HOT_CODE_3 10'h05F
`define COLD_CODE 10'h2F4
// strap detection window, 0.15 V to 1.15 V
`define STRAP_LO_CODE 10'h00F
`define STRAP_HI_CODE 10'h075
// uplink packet headers and default end reason
`define HDR_EPT 8'h02
`define HDR_CE 8'h03
`define HDR_POWER 8'h04
`define EPT_REASON 8'h03
// timing
`define CLK_KHZ 10000
`define CLAMP_HOLD_MS 200
`define BIT_PERIOD_US 500
`define CE_PERIOD_MS 250
`define CE_FAST_MS 50
`endif

// ---- design/rx_protect_pkg.sv ----
/*
 * types shared by the receiver control block.
 * assumes nothing of its surroundings.
 */
package rx_protect_pkg;
	// synchronised analog comparator and pin levels
	typedef struct packed {
		logic biasOk;
		logic ovOne;
		logic ovTwo;
		logic overCur;
		logic outShort;
		logic dieHot;
		logic regEnable_n;
	} protIn_t;
	// converter channels
	typedef enum logic [2:0] {CH_RECTIFIED_RAIL, CH_IOUT, CH_THERM, CH_OFFSET_STRAP, CH_COIL_STRAP} adcCh_t;
	// control sequence
	typedef enum logic [1:0] {ST_OFF, ST_STRAP_OFS, ST_STRAP_COIL, ST_RUN} ctlState_t;
endpackage

// ---- test/adc_model.sv ----
/*
 * converter partner: answers each request after a short or a long wait.
 * assumes the req/done handshake of the control block on the same clock.
 */
`timescale 1ns/10ps
module adc_model
	import rx_protect_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// handshake
	input wire logic adcReq,
	input adcCh_t adcChannel,
	output logic adcDone,
	output logic [9:0] adcResult
);
	logic [9:0] val; // code of the selected channel
	logic [2:0] cnt; // wait counter
	logic slow; // alternates prompt and slow answers
	// channel levels, strap codes inside the window
	always_comb
	begin
		case (adcChannel)
			CH_RECTIFIED_RAIL: val = 10'h3F0;
			CH_IOUT: val = 10'h155;
			CH_THERM: val = 10'h300;
			CH_OFFSET_STRAP: val = 10'h028;
			default: val = 10'h020;
		endcase
	end
	// result line shows the inverted value outside the done cycle
	assign adcResult = adcDone ? val : ~val;
	// done pulse only while a request stands
	always @(posedge clk)
	begin
		if (srst)
		begin
			adcDone <= 1'b0;
			cnt <= 3'h0;
			slow <= 1'b0;
		end
		else if (adcReq && !adcDone)
		begin
			cnt <= cnt + 3'h1;
			if (cnt == (slow ? 3'h5 : 3'h1))
			begin
				adcDone <= 1'b1;
				cnt <= 3'h0;
				slow <= !slow;
			end
		end
		else
			adcDone <= 1'b0;
	end
endmodule // adc_model

// ---- test/testbench.sv ----
/*
 * testbench of the receiver control block: register access, start-up,
 * protections. assumes the converter partner in adc_model.
 */
`timescale 1ns/10ps
module testbench
	import rx_protect_pkg::*;
;
	logic clk = 0, srst = 1, adcDone, adcReq, rectEnable, ldoEnable, currentLimit;
	logic hardCutoff, strapCurrentEn, clampOut, clampOe_n, hostIrq, on;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0;
	logic arready, rvalid, rready = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, loadModOut, loadModOe_n;
	logic [9:0] adcResult, voutTarget;
	logic [7:0] d;
	adcCh_t adcChannel;
	protIn_t protRaw = '0;
	int fail_count = 0, checked = 0, cyc = 0;
	wireless_rx_protection_control #(.CLAMP_CYCLES(20), .BIT_CYCLES(4), .CE_CYCLES(200),
		.CE_FAST_CYCLES(60)) uut (.*);
	adc_model partner (.*);
	always #50 clk = ~clk;
	// closing report
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			tally_and_finish;
		end
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// write one register index
	task wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= {22'h0, i, 2'h0};
		wdata <= {24'h0, v};
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 8'h00, {6'h0, bresp});
	endtask
	// read one register index into d
	task rd(input logic [7:0] i);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= {22'h0, i, 2'h0};
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		d = rdata[7:0];
	endtask
	initial
	begin
		wt(2);
		srst <= 1'b0;
		rd(8'h15);
		chk("option", 8'h12, d);
		protRaw.biasOk <= 1'b1;
		wt(60);
		chk("irq", 8'h01, {7'h0, hostIrq});
		rd(8'h06);
		chk("flags", 8'h02, d);
		rd(8'h06);
		chk("flags", 8'h00, d);
		rd(8'h14);
		chk("coil", 8'h14, d);
		rd(8'h18);
		chk("offset", 8'h0C, d);
		chk("strapI", 8'h00, {7'h0, strapCurrentEn});
		chk("rect", 8'h01, {7'h0, rectEnable});
		chk("ldo", 8'h01, {7'h0, ldoEnable});
		rd(8'h35);
		chk("rectified_rail", 8'hFC, d);
		rd(8'h33);
		chk("therm", 8'hC0, d);
		rd(8'h3F);
		chk("rresp", 8'h02, {6'h0, rresp});
		wr(8'h1D, 8'h40);
		rd(8'h1D);
		chk("vout", 8'h40, d);
		chk("target", 16'h0100, {6'h0, voutTarget});
		protRaw.regEnable_n <= 1'b1;
		wt(6);
		chk("ldoOff", 8'h00, {7'h0, ldoEnable});
		protRaw.regEnable_n <= 1'b0;
		protRaw.overCur <= 1'b1;
		wt(6);
		chk("clamp", 8'h00, {7'h0, clampOe_n});
		chk("limit", 8'h01, {7'h0, currentLimit});
		on = 0;
		repeat (90) @(posedge clk) if (loadModOe_n === 2'b00) on = 1;
		chk("uplink", 8'h01, {7'h0, on});
		chk("odLow", 8'h00, {5'h0, clampOut, loadModOut});
		rd(8'h06);
		chk("flags", 8'h08, d);
		protRaw.overCur <= 1'b0;
		protRaw.ovTwo <= 1'b1;
		wt(8);
		chk("cut", 8'h01, {7'h0, hardCutoff});
		chk("ldoOv", 8'h00, {7'h0, ldoEnable});
		rd(8'h06);
		chk("flags", 8'h10, d);
		protRaw.ovTwo <= 1'b0;
		protRaw.ovOne <= 1'b1;
		wt(6);
		chk("clampOv1", 8'h00, {7'h0, clampOe_n});
		rd(8'h06);
		chk("flags", 8'h20, d);
		protRaw.ovOne <= 1'b0;
		wt(6);
		chk("clampHold", 8'h00, {7'h0, clampOe_n});
		wt(12);
		chk("clampEnd", 8'h01, {7'h0, clampOe_n});
		chk("ldoBack", 8'h01, {7'h0, ldoEnable});
		protRaw.outShort <= 1'b1;
		wt(6);
		chk("ldoShort", 8'h00, {7'h0, ldoEnable});
		rd(8'h06);
		chk("flags", 8'h04, d);
		protRaw.outShort <= 1'b0;
		protRaw.dieHot <= 1'b1;
		wt(6);
		rd(8'h06);
		chk("flags", 8'h40, d);
		wr(8'h15, 8'h04);
		rd(8'h06);
		chk("flags", 8'h80, d);
		wr(8'h15, 8'h01);
		chk("track", 16'h0300, {6'h0, voutTarget});
		protRaw.biasOk <= 1'b0;
		wt(6);
		chk("rectOff", 8'h00, {7'h0, rectEnable});
		tally_and_finish;
	end
endmodule // testbench
